// ---- src/nhc_regs.sv ----
`timescale 1ns/1ps
`include "nhc_consts.svh"

module nhc_regs #(
  parameter int NODES = 6
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // register access, page 0 gateway, 1..NODES nodes
  input wire logic [2:0] page_i,
  input wire logic [6:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o,
  // gateway measurements, updated continuously
  input wire nhc_pkg::nhc_meas_type gw_meas_i,
  // record event from a node
  input wire logic rec_evt_i,
  input wire logic [2:0] rec_node_i,
  input wire nhc_pkg::nhc_hdr_type rec_hdr_i,
  input wire nhc_pkg::nhc_meas_type rec_meas_i,
  // fault conditions of a node, level per flag
  input wire logic [2:0] flt_node_i,
  input wire logic [6:0] flt_set_i,
  // command engines
  output logic [15:0] cmd_start_o,
  output logic [2:0] cmd_node_o,
  input wire logic [15:0] cmd_done_i,
  input wire nhc_pkg::nhc_hdr_type flash_hdr_i,
  input wire logic selftest_fail_i,
  // state shown outside
  output logic [15:0] cmd_pend_o,
  output logic [8:0] buf_ptr_o
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  nhc_pkg::nhc_hdr_type hdr_ff [NODES];
  nhc_pkg::nhc_meas_type meas_ff [NODES];
  nhc_pkg::nhc_meas_type gw_ff;
  logic [15:0] cmd_ff;
  logic [15:0] nxt_cmd;
  logic [2:0] cmd_node_ff;
  logic [15:0] start_ff;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic [8:0] buf_ptr_ff;
  logic [8:0] nxt_buf_ptr;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [6:0] a, input logic [6:0] o);
    hit = (a == o);
  endfunction

  wire logic on_node = (page_i != 3'd0) && (page_i <= 3'(NODES));
  wire logic [2:0] sel = 3'(page_i - 3'd1);
  wire logic cmd_wr = wr_i && on_node && hit(addr_i, `NHC_OFS_COMMAND);
  wire logic ptr_wr = wr_i && on_node && hit(addr_i, `NHC_OFS_BUF_PTR);
  wire logic [15:0] cmd_set = cmd_wr ? wdata_i : 16'h0000;
  wire logic [15:0] new_bits = cmd_set & ~cmd_ff;
  wire logic [15:0] int_done = cmd_ff & `NHC_CMD_INTERNAL;
  wire logic [15:0] all_done = int_done | cmd_done_i;
  wire logic clr_stat = int_done[`NHC_CMD_CLR_STATUS];
  wire logic buf_zero = int_done[`NHC_CMD_BUF_ZERO];
  wire logic retr_done = cmd_done_i[`NHC_CMD_RETRIEVE];
  wire logic test_done = cmd_done_i[`NHC_CMD_SELFTEST];

  // a constant, so the asynchronous reset branch loads no logic output
  localparam nhc_pkg::nhc_hdr_type HDR_RST = '{
    set_one: nhc_pkg::nhc_set_one_type'(`NHC_RST_SET_ONE),
    default: '0
  };

  // ----------------------------------------------------------------
  // command register
  // ----------------------------------------------------------------
  // a new write wins over a completion in the same cycle
  assign nxt_cmd = (cmd_ff & ~all_done) | cmd_set;
  // start pulse only for bits that go from idle to pending
  // bit 8 clear records, 14 load band, 12 save band, 9 erase band,
  // 6 save regs, 5 flash sum, 3 factory restore, 2 self-test
  wire logic [15:0] ext_start = new_bits & ~`NHC_CMD_INTERNAL;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmd_ff <= 16'h0000;
      start_ff <= 16'h0000;
      cmd_node_ff <= 3'h0;
    end else begin
      cmd_ff <= nxt_cmd;
      start_ff <= ext_start;
      if (cmd_wr) begin
        cmd_node_ff <= sel;
      end
    end
  end

  // ----------------------------------------------------------------
  // buffer index pointer
  // ----------------------------------------------------------------
  assign nxt_buf_ptr = buf_zero ? 9'h000 :
                       ptr_wr ? wdata_i[8:0] : buf_ptr_ff;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      buf_ptr_ff <= 9'h000;
    end else begin
      buf_ptr_ff <= nxt_buf_ptr;
    end
  end

  // ----------------------------------------------------------------
  // gateway measurements
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gw_ff <= '0;
    end else begin
      gw_ff <= gw_meas_i;
    end
  end

  // ----------------------------------------------------------------
  // per-node header and status
  // ----------------------------------------------------------------
  for (genvar n = 0; n < NODES; n++) begin : g_node
    wire logic rec_me = rec_evt_i && (rec_node_i == 3'(n));
    wire logic cmd_me = (cmd_node_ff == 3'(n));
    wire logic flt_me = (flt_node_i == 3'(n));
    nhc_pkg::nhc_hdr_type nxt_hdr;
    logic [15:0] st;

    always_comb begin
      nxt_hdr = hdr_ff[n];
      if (rec_me) begin
        nxt_hdr = rec_hdr_i;
      end
      if (retr_done && cmd_me) begin
        nxt_hdr = flash_hdr_i;
      end
      st = nxt_hdr.status;
      if (clr_stat && cmd_me) begin
        st[`NHC_STAT_LATCH_W-1:0] = 7'h00;
      end
      if (test_done && cmd_me) begin
        st[`NHC_STAT_SELFTEST] = selftest_fail_i;
      end
      if (flt_me) begin
        // a fault still present sets again over a clear
        st[`NHC_STAT_LATCH_W-1:0] = st[6:0] | flt_set_i;
      end
      nxt_hdr.status = st;
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        hdr_ff[n] <= HDR_RST;
        meas_ff[n] <= '0;
      end else begin
        hdr_ff[n] <= nxt_hdr;
        if (rec_me) begin
          meas_ff[n] <= rec_meas_i;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // a page with no node behind it indexes node 0; its selects stay low
  wire logic [2:0] rsel = on_node ? sel : 3'd0;
  wire logic on_gw = (page_i == 3'd0);
  nhc_pkg::nhc_hdr_type rh;
  nhc_pkg::nhc_meas_type rm;
  assign rh = hdr_ff[rsel];
  assign rm = meas_ff[rsel];

  // ----------------------------------------------------------------
  // read decode, one select line per register
  // ----------------------------------------------------------------
  wire logic s_gw_temp = on_gw && hit(addr_i, `NHC_OFS_GW_TEMP);
  wire logic s_gw_supply = on_gw && hit(addr_i, `NHC_OFS_GW_SUPPLY);
  wire logic s_temp = on_node && hit(addr_i, `NHC_OFS_NODE_TEMP);
  wire logic s_supply = on_node && hit(addr_i, `NHC_OFS_NODE_SUPPLY);
  wire logic s_buf_ptr = on_node && hit(addr_i, `NHC_OFS_BUF_PTR);
  wire logic s_status = on_node && hit(addr_i, `NHC_OFS_STATUS);
  wire logic s_x_state = on_node && hit(addr_i, `NHC_OFS_X_STATE);
  wire logic s_y_state = on_node && hit(addr_i, `NHC_OFS_Y_STATE);
  wire logic s_x_peak = on_node && hit(addr_i, `NHC_OFS_X_PEAK);
  wire logic s_y_peak = on_node && hit(addr_i, `NHC_OFS_Y_PEAK);
  wire logic s_time_lo = on_node && hit(addr_i, `NHC_OFS_TIME_LOW);
  wire logic s_time_hi = on_node && hit(addr_i, `NHC_OFS_TIME_HIGH);
  wire logic s_x_bin = on_node && hit(addr_i, `NHC_OFS_X_BIN);
  wire logic s_y_bin = on_node && hit(addr_i, `NHC_OFS_Y_BIN);
  wire logic s_set_one = on_node && hit(addr_i, `NHC_OFS_SET_ONE);
  wire logic s_set_two = on_node && hit(addr_i, `NHC_OFS_SET_TWO);

  // ----------------------------------------------------------------
  // read selection, an unselected register gives zero
  // ----------------------------------------------------------------
  wire logic [15:0] d_gw_temp = {16{s_gw_temp}} & gw_ff.temp;
  wire logic [15:0] d_gw_supply = {16{s_gw_supply}} & gw_ff.supply;
  wire logic [15:0] d_temp = {16{s_temp}} & rm.temp;
  wire logic [15:0] d_supply = {16{s_supply}} & rm.supply;
  wire logic [15:0] d_buf_ptr = {16{s_buf_ptr}} & {7'h00, buf_ptr_ff};
  wire logic [15:0] d_status = {16{s_status}} & rh.status;
  wire logic [15:0] d_x_state = {16{s_x_state}} & rh.x_state;
  wire logic [15:0] d_y_state = {16{s_y_state}} & rh.y_state;
  wire logic [15:0] d_x_peak = {16{s_x_peak}} & rh.x_peak;
  wire logic [15:0] d_y_peak = {16{s_y_peak}} & rh.y_peak;
  wire logic [15:0] d_time_lo = {16{s_time_lo}} & rh.time_stamp[15:0];
  wire logic [15:0] d_time_hi = {16{s_time_hi}} & rh.time_stamp[31:16];
  wire logic [15:0] d_x_bin = {16{s_x_bin}} & rh.x_bin;
  wire logic [15:0] d_y_bin = {16{s_y_bin}} & rh.y_bin;
  wire logic [15:0] d_set_one = {16{s_set_one}} & rh.set_one;
  wire logic [15:0] d_set_two = {16{s_set_two}} & rh.set_two;

  assign nxt_rdata = d_gw_temp | d_gw_supply | d_temp | d_supply
                   | d_buf_ptr | d_status | d_x_state | d_y_state
                   | d_x_peak | d_y_peak | d_time_lo | d_time_hi
                   | d_x_bin | d_y_bin | d_set_one | d_set_two;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_ff <= 16'h0000;
    end else if (rd_i) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_o = rdata_ff;
  assign cmd_start_o = start_ff;
  assign cmd_node_o = cmd_node_ff;
  assign cmd_pend_o = cmd_ff;
  assign buf_ptr_o = buf_ptr_ff;

endmodule // nhc_regs

// ---- src/nhc_consts.svh ----
// Operation
// - supply readout: unsigned, 0.44 mV per count
// - temperature: offset binary, 4584 is 0 C
// - record event refreshes the whole header set
// - retrieve bit loads header from flash
// - settings one [15:14] sample rate option
// - settings one [13:12] window, code 11 unused
// - settings one [11:10] signal range, [9:8] ignored
// - settings one low byte is FFT averages
// - settings two [3:0] averaging count setting
// - 32-bit seconds time stamp, two words
// - write one starts function, bit self-clears
// - bit 8 clears records and buffers
// - bit 14 loads alarm band at pointer
// - bit 12 saves alarm bands to SRAM
// - bit 10 forces buffer pointer to zero
// - bit 9 erases alarm bands in flash
// - bit 6 saves registers to flash
// - bit 5 runs flash sum check
// - bit 3 restores factory settings, clears buffers
// - bit 2 self-test, result in status bit 5
// - bit 4 clears latched status, faults reassert
`ifndef NHC_CONSTS_SVH
`define NHC_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define NHC_OFS_NODE_TEMP 7'h0a
`define NHC_OFS_NODE_SUPPLY 7'h0c
`define NHC_OFS_GW_TEMP 7'h0c
`define NHC_OFS_GW_SUPPLY 7'h0e
`define NHC_OFS_BUF_PTR 7'h12
`define NHC_OFS_STATUS 7'h34
`define NHC_OFS_COMMAND 7'h36
`define NHC_OFS_X_STATE 7'h38
`define NHC_OFS_Y_STATE 7'h3a
`define NHC_OFS_X_PEAK 7'h3c
`define NHC_OFS_Y_PEAK 7'h3e
`define NHC_OFS_TIME_LOW 7'h40
`define NHC_OFS_TIME_HIGH 7'h42
`define NHC_OFS_X_BIN 7'h44
`define NHC_OFS_Y_BIN 7'h46
`define NHC_OFS_SET_ONE 7'h4c
`define NHC_OFS_SET_TWO 7'h4e

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define NHC_RST_SET_ONE 16'h0008
`define NHC_RST_ZERO 16'h0000
`define NHC_BUF_PTR_W 9
`define NHC_STAT_LATCH_W 7
`define NHC_STAT_SELFTEST 5

// ----------------------------------------------------------------
// command bits
// ----------------------------------------------------------------
`define NHC_CMD_SELFTEST 2
`define NHC_CMD_CLR_STATUS 4
`define NHC_CMD_BUF_ZERO 10
`define NHC_CMD_RETRIEVE 13
`define NHC_CMD_INTERNAL 16'h0410

`endif

// ---- src/nhc_pkg.sv ----
package nhc_pkg;

  // settings one: rate, window, range, unused, FFT averages
  typedef struct packed {
    logic [1:0] rate;
    logic [1:0] window;
    logic [1:0] range;
    logic [1:0] spare;
    logic [7:0] averages;
  } nhc_set_one_type;

  // settings two: unused upper field, averaging count setting
  typedef struct packed {
    logic [11:0] spare;
    logic [3:0] avg_count;
  } nhc_set_two_type;

  typedef struct packed {
    logic [15:0] status;
    logic [15:0] x_state;
    logic [15:0] y_state;
    logic [15:0] x_peak;
    logic [15:0] y_peak;
    logic [31:0] time_stamp;
    logic [15:0] x_bin;
    logic [15:0] y_bin;
    nhc_set_one_type set_one;
    nhc_set_two_type set_two;
  } nhc_hdr_type;

  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] supply;
  } nhc_meas_type;

endpackage

// ---- test/nhc_monitor.sv ----
`timescale 1ns/1ps
`include "nhc_consts.svh"
module nhc_monitor (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // register access
  input wire logic [2:0] page_i,
  input wire logic [6:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] wdata_i,
  input wire logic [15:0] rdata_o,
  // command engines
  input wire logic [15:0] cmd_start_o,
  input wire logic [15:0] cmd_done_i,
  input wire logic [15:0] cmd_pend_o,
  input wire logic [8:0] buf_ptr_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  logic cw;
  assign cw = wr_i && addr_i == `NHC_OFS_COMMAND && page_i != 3'h0
    && page_i != 3'h7;
  retr_start_a: assert property (cw && wdata_i[13] && !cmd_pend_o[13]
    |=> cmd_start_o[13] ##1 !cmd_start_o[13]) else $error("no start");
  pend_set_a: assert property (cw |=> (cmd_pend_o & $past(wdata_i)
    & 16'hfbef) == ($past(wdata_i) & 16'hfbef)) else $error("no pend");
  done_clr_a: assert property (!cw |=> (cmd_pend_o & $past(cmd_done_i))
    == 16'h0000) else $error("pend kept");
  int_bits_a: assert property ((cmd_start_o & 16'h0410) == 16'h0000)
    else $error("internal start");
  // pending bit shows one edge after the write, the pointer one edge later
  buf_zero_a: assert property (cw && wdata_i[10]
    |=> ##1 buf_ptr_o == 9'h000) else $error("ptr not zero");
  clr_done_a: assert property (cw && wdata_i[4] ##1 !cw
    |=> !cmd_pend_o[4]) else $error("clear stuck");
  zero_cmd_a: assert property (cw && wdata_i == 16'h0000
    |=> cmd_start_o == 16'h0000) else $error("zero started");
  rd_hold_a: assert property (!rd_i |=> $stable(rdata_o))
    else $error("rdata moved");
  bad_read_a: assert property (rd_i && (page_i == 3'h7 || addr_i == 7'h7e)
    |=> rdata_o == 16'h0000) else $error("bad read data");
  cover property (cw && wdata_i[13]);
  cover property (cmd_done_i[2]);
  cover property (rd_i && page_i == 3'h0);
endmodule // nhc_monitor

bind nhc_regs nhc_monitor i_nhc_monitor (.ref_clk_i, .nrst_i, .page_i,
  .addr_i, .wr_i, .rd_i, .wdata_i, .rdata_o, .cmd_start_o, .cmd_done_i,
  .cmd_pend_o, .buf_ptr_o);

// ---- test/nhc_engine_model.sv ----
`timescale 1ns/1ps
module nhc_engine_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // start pulses in, completion pulses out
  input wire logic slow_i,
  input wire logic [15:0] cmd_start_i,
  output logic [15:0] cmd_done_o
);
  // each engine finishes after 1 or 8 cycles
  logic [7:0][15:0] dly_ff;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dly_ff <= '0;
    end else begin
      dly_ff <= {dly_ff[6:0], cmd_start_i};
    end
  end
  assign cmd_done_o = slow_i ? dly_ff[7] : dly_ff[0];
endmodule // nhc_engine_model

// ---- test/nhc_regs_tb.sv ----
`timescale 1ns/1ps
module nhc_regs_tb;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [2:0] page_i = 3'h0, rec_node_i = 3'h0, flt_node_i = 3'h0, cnode, n;
  logic [6:0] addr_i = 7'h00, flt_set_i = 7'h00;
  logic wr_i = 1'b0, rd_i = 1'b0, rec_evt_i = 1'b0, fail = 1'b0;
  logic slow = 1'b0;
  logic [15:0] wdata_i = 16'h0000, rdata_o, start, done, pend, v;
  logic [8:0] bptr, p9;
  nhc_pkg::nhc_meas_type gw = '0, meas = '0, m;
  nhc_pkg::nhc_hdr_type hdr = '0, fh = '0, h;
  logic [6:0] ha [11] = '{7'h34, 7'h38, 7'h3a, 7'h3c, 7'h3e, 7'h40, 7'h42,
    7'h44, 7'h46, 7'h4c, 7'h4e};
  int num_errors = 0, n_compared = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  nhc_regs i_nhc_regs (.ref_clk_i, .nrst_i, .page_i, .addr_i, .wr_i, .rd_i,
    .wdata_i, .rdata_o, .gw_meas_i(gw), .rec_evt_i, .rec_node_i,
    .rec_hdr_i(hdr), .rec_meas_i(meas), .flt_node_i, .flt_set_i,
    .cmd_start_o(start), .cmd_node_o(cnode), .cmd_done_i(done),
    .flash_hdr_i(fh), .selftest_fail_i(fail), .cmd_pend_o(pend),
    .buf_ptr_o(bptr));
  nhc_engine_model i_nhc_engine_model (.ref_clk_i, .nrst_i, .slow_i(slow),
    .cmd_start_i(start), .cmd_done_o(done));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [2:0] p,
      input logic [6:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    wr_i <= w;
    rd_i <= !w;
    page_i <= p;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic idle();
    for (int k = 0; k < 20 && pend !== 16'h0000; k++) begin
      @(posedge ref_clk_i);
      #1;
    end
  endtask
  function automatic logic [15:0] ex(nhc_pkg::nhc_hdr_type x, int i);
    logic [175:0] t;
    t = x;
    if (i == 5) return x.time_stamp[15:0];
    if (i == 6) return x.time_stamp[31:16];
    return t[175 - 16 * i -: 16];
  endfunction
  task automatic chk_hdr(input logic [2:0] p, input nhc_pkg::nhc_hdr_type x);
    for (int i = 0; i < 11; i++) begin
      acc(1'b0, p, ha[i], 16'h0000);
      chk(v, ex(x, i));
    end
  endtask
  function automatic nhc_pkg::nhc_hdr_type rh();
    logic [191:0] t;
    for (int i = 0; i < 6; i++) t[i * 32 +: 32] = $urandom;
    return t[175:0];
  endfunction
  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    num_errors++;
    tally_and_finish();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h8b00_aeb9));
    repeat (3) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    h = '0;
    h.set_one = 16'h0008;
    chk_hdr(3'h1, h);
    for (int i = 0; i < 4; i++) begin
      h = rh();
      h.set_one.rate = 2'(i);
      h.set_one.window = 2'(i);
      h.set_one.range = 2'(i);
      if (i == 3) h.set_one.averages = 8'hff;
      h.status[6:0] = 7'h00;
      m = $urandom;
      n = 3'($urandom_range(5));
      @(posedge ref_clk_i);
      hdr <= h;
      meas <= m;
      rec_node_i <= n;
      rec_evt_i <= 1'b1;
      @(posedge ref_clk_i);
      rec_evt_i <= 1'b0;
      chk_hdr(n + 3'h1, h);
      acc(1'b0, n + 3'h1, 7'h0a, 16'h0000);
      chk(v, m.temp);
      acc(1'b0, n + 3'h1, 7'h0c, 16'h0000);
      chk(v, m.supply);
    end
    @(posedge ref_clk_i);
    gw <= '{temp: 16'h11e8, supply: 16'h1d4c};
    acc(1'b0, 3'h0, 7'h0c, 16'h0000);
    chk(v, 16'h11e8);
    acc(1'b0, 3'h0, 7'h0e, 16'h0000);
    chk(v, 16'h1d4c);
    acc(1'b0, 3'h7, 7'h4c, 16'h0000);
    chk(v, 16'h0000);
    acc(1'b0, 3'h1, 7'h7e, 16'h0000);
    chk(v, 16'h0000);
    p9 = 9'($urandom);
    acc(1'b1, 3'h1, 7'h12, {7'h00, p9});
    acc(1'b0, 3'h1, 7'h12, 16'h0000);
    chk(v, {7'h00, p9});
    acc(1'b1, 3'h1, 7'h36, 16'h0400);
    @(posedge ref_clk_i);
    #1 chk({7'h00, bptr}, 16'h0000);
    acc(1'b1, 3'h1, 7'h36, 16'h0000);
    @(posedge ref_clk_i);
    slow <= 1'b1;
    for (int b = 0; b < 16; b++) begin
      acc(1'b1, 3'h1, 7'h36, 16'h0001 << b);
      idle();
      chk(pend, 16'h0000);
    end
    repeat (10) @(posedge ref_clk_i);
    slow <= 1'b0;
    fh <= rh();
    acc(1'b1, 3'h2, 7'h36, 16'h2000);
    idle();
    chk({13'h0000, cnode}, 16'h0001);
    chk_hdr(3'h2, fh);
    @(posedge ref_clk_i);
    flt_node_i <= 3'h1;
    flt_set_i <= 7'h05;
    acc(1'b1, 3'h2, 7'h36, 16'h0010);
    @(posedge ref_clk_i);
    flt_set_i <= 7'h00;
    acc(1'b0, 3'h2, 7'h34, 16'h0000);
    chk(v, {fh.status[15:7], 7'h05});
    @(posedge ref_clk_i);
    fail <= 1'b1;
    acc(1'b1, 3'h2, 7'h36, 16'h0004);
    idle();
    acc(1'b0, 3'h2, 7'h34, 16'h0000);
    chk(v, {fh.status[15:7], 7'h25});
    tally_and_finish();
  end
endmodule // nhc_regs_tb
